/* common/scbc_pkg.sv */
// ==========================================================
// capture buffer constants and carriers
package scbc_pkg;
  // ========================================================
  // widths and depths
  localparam int DATA_W = 8; // one converted sample byte
  localparam int REG_W = 16; // register port data width
  localparam int ADDR_W = 8; // register port address width
  localparam int FIFO_DEPTH = 16; // capture buffer entries
  localparam int FIFO_CNT_W = $clog2(FIFO_DEPTH + 1); // fill count width

  // ========================================================
  // register map
  localparam logic [7:0] BUF_CTRL_OFFSET = 8'h0f; // buffer control register
  localparam logic [7:0] STATUS_OFFSET = 8'h10; // buffer status register
  localparam int DUAL_PORT_POS = 12; // dual_port_output_bit
  localparam int STOP_FULL_POS = 13; // stop_on_full_bit
  localparam logic [15:0] BUF_CTRL_MASK = 16'h3000; // writable control bits
  localparam logic [15:0] BUF_CTRL_RESET = 16'h0000; // wrap mode, single port
  localparam int STAT_FULL_POS = 0; // status: full flag
  localparam int STAT_EMPTY_POS = 1; // status: empty flag
  localparam int STAT_OOR_POS = 2; // status: out of range
  localparam int STAT_WREQ_POS = 3; // status: synced write request
  localparam int STAT_COUNT_POS = 8; // status: fill count field

  // ========================================================
  // synchroniser lanes
  localparam int SYNC_N = 4; // number of outside inputs
  localparam int SYNC_WREQ = 0; // write request lane
  localparam int SYNC_REN = 1; // read enable lane
  localparam int SYNC_RCLK = 2; // read clock lane
  localparam int SYNC_BRST = 3; // buffer reset lane
  localparam logic EMPTY_RESET = 1'b1; // buffer starts empty

  // ========================================================
  // carriers and states
  typedef struct packed
  {
    logic buffer_full_flag; // buffer holds its maximum
    logic buffer_empty_flag; // buffer holds nothing
    logic out_of_range; // input left linear range during capture
  } scbc_flags_t;

  typedef enum logic {RD_IDLE, RD_SECOND} scbc_rd_state_t;
endpackage

/* rtl/scbc_capture_ctrl.sv */
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
// Operation
// R1: read enable drains one byte per read clock; in dual mode the code drains two, one on the rise and one the next cycle
// R2: write request stores one byte per sample clock
// R3: controller never raises read enable during writes
// R4: write request synchronised before use
// R5: controller keeps read clock running freely
// R6: output data and empty follow read clock
// R7: buffer reset returns control logic to start
// R8: synced write request driven on its pin
// R9: out of range sticks during capture
// R10: out of range clears on read or reset
// R11: full flag raised when buffer holds maximum
// R12: full with wrap mode overwrites oldest data
// R13: full flag cleared by read or reset
// R14: empty flag raised on read clock when empty
// R15: empty flag cleared when a write lands
// R16: later port holds last byte when idle
// R17: dual mode splits bytes, else earlier port off
// R18: data strobes follow read clock, aligned with data
// R19: stop mode halts writes once full
module scbc_capture_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_request_async,
  input wire logic read_enable_async,
  input wire logic read_clock_in,
  input wire logic buffer_reset_in,
  input wire logic [scbc_pkg::DATA_W-1:0] sample_data,
  input wire logic sample_over_range,
  input wire logic [scbc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scbc_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [scbc_pkg::REG_W-1:0] reg_rdata,
  output logic [scbc_pkg::DATA_W-1:0] later_sample_port,
  output logic [scbc_pkg::DATA_W-1:0] earlier_sample_port,
  output logic earlier_sample_port_oe,
  output logic output_data_strobe_later,
  output logic output_data_strobe_earlier,
  output logic write_request_synced_out,
  output logic capture_accept,
  output scbc_pkg::scbc_flags_t buffer_flags
);
  // ========================================================
  // state
  typedef struct packed
  {
    logic [scbc_pkg::SYNC_N-1:0] s1; // first sync stage
    logic [scbc_pkg::SYNC_N-1:0] s2; // second sync stage
    logic [scbc_pkg::SYNC_N-1:0] s3; // third sync stage
    logic [scbc_pkg::SYNC_N-1:0] lvl; // agreed levels
    logic rclk_prev; // read clock level last cycle
    logic [scbc_pkg::REG_W-1:0] ctrl; // buffer control register
    logic [scbc_pkg::REG_W-1:0] rdata; // read data, one cycle
    logic [scbc_pkg::DATA_W-1:0] later; // later sample port
    logic [scbc_pkg::DATA_W-1:0] earlier; // earlier sample port
    logic [scbc_pkg::DATA_W-1:0] hold; // first byte of a pair
    logic strobe_l; // strobe for later port
    logic strobe_e; // strobe for earlier port
    logic full; // full flag
    logic empty; // empty flag
    logic oor; // out of range flag
    scbc_pkg::scbc_rd_state_t rd_st; // read sequencer
  } scbc_state_t;

  scbc_state_t st_r; // registered state
  scbc_state_t st_nxt; // next state
  logic [scbc_pkg::SYNC_N-1:0] in_vec; // raw outside inputs
  logic [scbc_pkg::SYNC_N-1:0] diff; // stages two and three disagree
  logic wreq; // synced write request
  logic ren; // synced read enable
  logic flush; // synced buffer reset
  logic rclk_rise; // read clock rising edge
  logic rclk_fall; // read clock falling edge
  logic dual; // dual port mode
  logic stop_full; // stop on full mode
  logic fifo_ready; // buffer accepts a byte
  logic fifo_valid; // buffer holds a byte
  logic fifo_full; // buffer at maximum
  logic [scbc_pkg::DATA_W-1:0] fifo_data; // oldest byte
  logic [scbc_pkg::FIFO_CNT_W-1:0] fifo_count; // bytes held
  logic push; // byte stored this cycle
  logic pop; // byte drained this cycle

  // ========================================================
  // input synchronisation
  assign in_vec = {buffer_reset_in, read_clock_in, read_enable_async, write_request_async};
  assign diff = st_r.s2 ^ st_r.s3;
  assign wreq = st_r.lvl[scbc_pkg::SYNC_WREQ];
  assign ren = st_r.lvl[scbc_pkg::SYNC_REN];
  assign flush = st_r.lvl[scbc_pkg::SYNC_BRST];
  // read clock is only sampled, so it must keep toggling to drain data
  assign rclk_rise = st_r.lvl[scbc_pkg::SYNC_RCLK] && !st_r.rclk_prev; // R5
  assign rclk_fall = !st_r.lvl[scbc_pkg::SYNC_RCLK] && st_r.rclk_prev;
  assign dual = st_r.ctrl[scbc_pkg::DUAL_PORT_POS];
  assign stop_full = st_r.ctrl[scbc_pkg::STOP_FULL_POS];

  // ========================================================
  // buffer handshakes
  // stop mode drops the ready, which stalls storing here
  assign push = wreq && fifo_ready && !flush; // R2 R19
  // controller keeps read enable low while writing, so no clash here
  assign pop = fifo_valid && !flush && // R3
    ((st_r.rd_st == scbc_pkg::RD_IDLE && rclk_rise && ren) || // R1
     (st_r.rd_st == scbc_pkg::RD_SECOND));
  assign capture_accept = fifo_ready;

  scbc_fifo #(
    .WIDTH(scbc_pkg::DATA_W),
    .DEPTH(scbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(flush),
    .overwrite(!stop_full), // R12
    .in_valid(wreq && !flush),
    .in_ready(fifo_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .full(fifo_full),
    .count(fifo_count)
  );

  // ========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // three stages, a change counts once stages two and three agree
    st_nxt.s1 = in_vec; // R4
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = (~diff & st_r.s3) | (diff & st_r.lvl);
    st_nxt.rclk_prev = st_r.lvl[scbc_pkg::SYNC_RCLK];

    // register port, read data valid only in the following cycle
    st_nxt.rdata = '0;
    if (reg_write && reg_addr == scbc_pkg::BUF_CTRL_OFFSET)
      st_nxt.ctrl = reg_wdata & scbc_pkg::BUF_CTRL_MASK;
    if (reg_read)
    begin
      case (reg_addr)
        scbc_pkg::BUF_CTRL_OFFSET:
          st_nxt.rdata = st_r.ctrl;
        scbc_pkg::STATUS_OFFSET:
        begin
          st_nxt.rdata[scbc_pkg::STAT_FULL_POS] = st_r.full;
          st_nxt.rdata[scbc_pkg::STAT_EMPTY_POS] = st_r.empty;
          st_nxt.rdata[scbc_pkg::STAT_OOR_POS] = st_r.oor;
          st_nxt.rdata[scbc_pkg::STAT_WREQ_POS] = wreq;
          st_nxt.rdata[scbc_pkg::STAT_COUNT_POS +: scbc_pkg::FIFO_CNT_W] = fifo_count;
        end
        default:
          st_nxt.rdata = '0; // unmapped reads as zero
      endcase
    end

    // strobes drop with the read clock, set below wins
    if (rclk_fall) // R18
    begin
      st_nxt.strobe_l = 1'b0;
      st_nxt.strobe_e = 1'b0;
    end

    // read sequencer, output ports change only on or one cycle after a read clock rise
    case (st_r.rd_st)
      scbc_pkg::RD_IDLE:
      begin
        if (pop) // R6
        begin
          if (dual) // R17
          begin
            st_nxt.hold = fifo_data;
            st_nxt.rd_st = scbc_pkg::RD_SECOND;
          end
          else
          begin
            st_nxt.later = fifo_data;
            st_nxt.strobe_l = 1'b1; // R18
          end
        end
        // without a pop the later port keeps its last byte
      end
      scbc_pkg::RD_SECOND:
      begin
        // earlier byte goes to the second port; a lone byte leaves later as is
        if (pop)
          st_nxt.later = fifo_data; // R17
        st_nxt.earlier = st_r.hold;
        st_nxt.strobe_l = 1'b1; // R18
        st_nxt.strobe_e = 1'b1;
        st_nxt.rd_st = scbc_pkg::RD_IDLE;
      end
      default:
        st_nxt.rd_st = scbc_pkg::RD_IDLE;
    endcase

    // full flag follows the buffer, a read clears it
    if (pop)
      st_nxt.full = 1'b0; // R13
    else
      st_nxt.full = fifo_full; // R11

    // empty flag: set on the read clock, a landed write wins
    if (rclk_rise && !fifo_valid)
      st_nxt.empty = 1'b1; // R14
    if (push)
      st_nxt.empty = 1'b0; // R15

    // out of range: a read clears, a new excursion wins
    if (pop)
      st_nxt.oor = 1'b0; // R10
    if (push && sample_over_range)
      st_nxt.oor = 1'b1; // R9

    // buffer reset overrides sequencer, flags and strobes; the later port and register file keep their values, the earlier port still takes a held byte
    if (flush) // R7
    begin
      st_nxt.rd_st = scbc_pkg::RD_IDLE;
      st_nxt.full = 1'b0;
      st_nxt.empty = scbc_pkg::EMPTY_RESET;
      st_nxt.oor = 1'b0;
      st_nxt.strobe_l = 1'b0;
      st_nxt.strobe_e = 1'b0;
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.empty <= scbc_pkg::EMPTY_RESET;
      st_r.ctrl <= scbc_pkg::BUF_CTRL_RESET;
      st_r.rd_st <= scbc_pkg::RD_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ========================================================
  // outputs
  assign reg_rdata = st_r.rdata;
  assign later_sample_port = st_r.later;
  assign earlier_sample_port = st_r.earlier;
  assign earlier_sample_port_oe = dual; // R17
  assign output_data_strobe_later = st_r.strobe_l;
  assign output_data_strobe_earlier = st_r.strobe_e;
  assign write_request_synced_out = wreq; // R8
  assign buffer_flags.buffer_full_flag = st_r.full;
  assign buffer_flags.buffer_empty_flag = st_r.empty;
  assign buffer_flags.out_of_range = st_r.oor;

  // ========================================================
  // assertions
  AST_WREQ_SYNC: assert property (@(posedge clock) disable iff (!rst_n) // R4 R8
    $rose(write_request_synced_out) |-> $past(write_request_async, 3) &&
      $past(write_request_async, 4))
    else $error("synced write request rose without a stable input");

  AST_PUSH_COUNT: assert property (@(posedge clock) disable iff (!rst_n) // R2
    (push && !pop && !fifo_full) |=> fifo_count == $past(fifo_count) + 5'h01)
    else $error("stored byte did not raise the fill count");

  AST_WRAP_FULL: assert property (@(posedge clock) disable iff (!rst_n) // R12
    (wreq && !flush && fifo_full && !stop_full && !pop) |-> push ##1 fifo_full)
    else $error("wrap mode did not overwrite when full");

  AST_STOP_FULL: assert property (@(posedge clock) disable iff (!rst_n) // R19
    (fifo_full && stop_full) |-> !push && !capture_accept)
    else $error("stop mode stored into a full buffer");

  AST_READ_STEP: assert property (@(posedge clock) disable iff (!rst_n) // R1
    (st_r.rd_st == scbc_pkg::RD_IDLE && rclk_rise && ren && fifo_valid && !flush)
      |-> pop ##[1:2] output_data_strobe_later)
    else $error("read clock edge did not drain a byte");

  AST_FULL_SET: assert property (@(posedge clock) disable iff (!rst_n) // R11
    (fifo_full && !pop && !flush) |=> buffer_flags.buffer_full_flag)
    else $error("full flag missing while buffer full");

  AST_FULL_CLR: assert property (@(posedge clock) disable iff (!rst_n) // R13
    (pop || flush) |=> !buffer_flags.buffer_full_flag)
    else $error("full flag survived a read or reset");

  AST_EMPTY_SET: assert property (@(posedge clock) disable iff (!rst_n) // R14
    (rclk_rise && !fifo_valid && !push) |=> buffer_flags.buffer_empty_flag)
    else $error("empty flag not raised on read clock");

  AST_EMPTY_CLR: assert property (@(posedge clock) disable iff (!rst_n) // R15
    (push && !flush) |=> !buffer_flags.buffer_empty_flag)
    else $error("empty flag survived a write");

  AST_OOR: assert property (@(posedge clock) disable iff (!rst_n) // R9
    (push && sample_over_range) |=> buffer_flags.out_of_range)
    else $error("out of range not captured");

  AST_OOR_CLR: assert property (@(posedge clock) disable iff (!rst_n) // R10
    ((pop || flush) && !(push && sample_over_range)) |=> !buffer_flags.out_of_range)
    else $error("out of range survived a read or reset");

  AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // R16
    (!ren && st_r.rd_st == scbc_pkg::RD_IDLE) |=> $stable(later_sample_port))
    else $error("later port changed while reads are off");

  AST_RESET: assert property (@(posedge clock) disable iff (!rst_n) // R7
    flush |=> fifo_count == '0 && buffer_flags.buffer_empty_flag &&
      !output_data_strobe_later)
    else $error("buffer reset did not restore initial state");

  AST_SINGLE: assert property (@(posedge clock) disable iff (!rst_n) // R17
    (!dual)[*2] |-> !output_data_strobe_earlier || $past(output_data_strobe_earlier))
    else $error("earlier strobe rose in single port mode");
endmodule

/* rtl/scbc_fifo.sv */
`timescale 1ns/1ps
// ==========================================================
// capture buffer storage with optional overwrite of oldest
module scbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic overwrite,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
  localparam int CNT_W = $clog2(DEPTH + 1); // count width

  // ========================================================
  // state
  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage array
    logic [PTR_W-1:0] wr_ptr; // next slot to write
    logic [PTR_W-1:0] rd_ptr; // oldest entry
    logic [CNT_W-1:0] count; // entries held
  } scbc_fifo_state_t;

  scbc_fifo_state_t st_r; // registered state
  scbc_fifo_state_t st_nxt; // next state
  logic do_push; // entry accepted
  logic do_pop; // entry drained
  logic drop; // oldest entry overwritten

  // pointer step with wrap, depth need not be a power of two
  function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1))
      return '0;
    return p + PTR_W'(1);
  endfunction

  // ========================================================
  // handshakes
  assign full = (st_r.count == CNT_W'(DEPTH));
  assign in_ready = !full || overwrite; // stop mode stalls the source
  assign out_valid = (st_r.count != '0);
  assign out_data = st_r.mem[st_r.rd_ptr];
  assign count = st_r.count;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign drop = do_push && full && !do_pop;

  // next state
  always_comb
  begin
    st_nxt = st_r;
    if (flush)
    begin
      // flush empties without touching stored bytes
      st_nxt.wr_ptr = '0;
      st_nxt.rd_ptr = '0;
      st_nxt.count = '0;
    end
    else
    begin
      if (do_push)
      begin
        st_nxt.mem[st_r.wr_ptr] = in_data;
        st_nxt.wr_ptr = step(st_r.wr_ptr);
      end
      // overwrite advances the oldest pointer with the writer
      if (do_pop || drop)
        st_nxt.rd_ptr = step(st_r.rd_ptr);
      if (do_push && !do_pop && !full)
        st_nxt.count = st_r.count + CNT_W'(1);
      else if (do_pop && !do_push)
        st_nxt.count = st_r.count - CNT_W'(1);
    end
  end

  // registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

/* tb/scbc_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================================
// capture controller on the far side of the buffer pins
module scbc_ctrl_model (
  input wire logic clock,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic brst_cmd,
  output logic write_request_async,
  output logic read_enable_async,
  output logic read_clock_in,
  output logic buffer_reset_in
);
  // ========================================================
  // read clock: runs free, phase unrelated to the sample clock
  initial
  begin
    read_clock_in = 1'b0;
    #3.3;
    forever
      #62.5 read_clock_in = ~read_clock_in;
  end

  // ========================================================
  // request levels, all quiet at time zero
  initial
  begin
    write_request_async = 1'b0;
    read_enable_async = 1'b0;
    buffer_reset_in = 1'b0;
  end

  // read enable may stay up, but never rises over a live write
  always @(posedge clock)
  begin
    write_request_async <= wr_cmd & ~read_enable_async;
    read_enable_async <= rd_cmd & (read_enable_async | ~write_request_async);
    buffer_reset_in <= brst_cmd;
  end
endmodule

/* tb/tb_sample_capture_buffer_control.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the capture buffer control
module tb_sample_capture_buffer_control;
  logic clock; // sample clock, 8 ns
  logic rst_n; // sync reset, active low
  logic wr_cmd; // bench asks the controller to write
  logic rd_cmd; // bench asks the controller to read
  logic brst_cmd; // bench asks for a buffer reset
  logic write_request_async;
  logic read_enable_async;
  logic read_clock_in;
  logic buffer_reset_in;
  logic [7:0] sample_data; // running count, so holes show up
  logic sample_over_range;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic [7:0] later_sample_port;
  logic [7:0] earlier_sample_port;
  logic earlier_sample_port_oe;
  logic output_data_strobe_later;
  logic output_data_strobe_earlier;
  logic write_request_synced_out;
  logic capture_accept;
  scbc_pkg::scbc_flags_t buffer_flags;
  logic strobe_d = 1'b0; // strobe one edge ago
  logic [7:0] rd_q[$]; // bytes seen on the later port
  logic [7:0] er_q[$]; // bytes seen on the earlier port
  logic [7:0] v_drop; // sample count when writing stopped
  int n_errors = 0;
  int cmp_count = 0;

  // ========================================================
  // design and far side
  scbc_ctrl_model ctrl (.clock(clock), .wr_cmd(wr_cmd), .rd_cmd(rd_cmd),
    .brst_cmd(brst_cmd), .write_request_async(write_request_async),
    .read_enable_async(read_enable_async), .read_clock_in(read_clock_in),
    .buffer_reset_in(buffer_reset_in));

  scbc_capture_ctrl dut (.clock(clock), .rst_n(rst_n),
    .write_request_async(write_request_async), .read_enable_async(read_enable_async),
    .read_clock_in(read_clock_in), .buffer_reset_in(buffer_reset_in),
    .sample_data(sample_data), .sample_over_range(sample_over_range),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .later_sample_port(later_sample_port),
    .earlier_sample_port(earlier_sample_port),
    .earlier_sample_port_oe(earlier_sample_port_oe),
    .output_data_strobe_later(output_data_strobe_later),
    .output_data_strobe_earlier(output_data_strobe_earlier),
    .write_request_synced_out(write_request_synced_out),
    .capture_accept(capture_accept), .buffer_flags(buffer_flags));

  // ========================================================
  // clock and sample source
  initial
  begin
    clock = 1'b0;
    forever
      #4 clock = ~clock;
  end

  // samples climb by one each cycle from a random start
  always @(posedge clock)
    sample_data <= sample_data + 8'h01;

  // collect one read per rising later strobe
  always @(posedge clock)
  begin
    strobe_d <= output_data_strobe_later;
    if (output_data_strobe_later === 1'b1 && strobe_d === 1'b0)
    begin
      rd_q.push_back(later_sample_port);
      er_q.push_back(earlier_sample_port);
      check(output_data_strobe_earlier, earlier_sample_port_oe);
    end
  end

  // ========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] step(input logic [7:0] b, input int k);
    return b + 8'(k);
  endfunction

  // status word: count, oor, empty, full; request idle
  function automatic logic [15:0] stat(input int n, input logic f, input logic e,
    input logic o);
    return {3'h0, 5'(n), 5'h00, o, e, f};
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // hold the write request n cycles, optional over-range pulse
  task automatic write_burst(input int n, input int oor_at);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      wr_cmd <= 1'b1;
      sample_over_range <= (i == oor_at);
    end
    @(posedge clock);
    wr_cmd <= 1'b0;
    sample_over_range <= 1'b0;
    v_drop = sample_data;
    #1 check(write_request_synced_out, 1'b1);
    repeat (10) @(posedge clock);
    #1 check(write_request_synced_out, 1'b0);
  endtask

  // read until n strobes were seen, then let 40 more cycles, over two read clock periods, pass
  task automatic drain(input int n);
    rd_q.delete();
    er_q.delete();
    @(posedge clock);
    rd_cmd <= 1'b1;
    for (int i = 0; i < 800 && rd_q.size() < n; i++)
      @(posedge clock);
    repeat (40) @(posedge clock);
    rd_cmd <= 1'b0;
    repeat (40) @(posedge clock);
    check(16'(rd_q.size()), 16'(n));
  endtask

  task automatic chk_seq();
    for (int i = 1; i < rd_q.size(); i++)
      check(rd_q[i], step(rd_q[0], i));
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ========================================================
  // watchdog, far beyond the well under two thousand cycles the tests need
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end

  // ========================================================
  // main sequence
  initial
  begin
    int n;
    logic [7:0] d_wrap;
    logic [7:0] d_stop;
    rst_n = 1'b0;
    wr_cmd = 1'b0;
    rd_cmd = 1'b0;
    brst_cmd = 1'b0;
    sample_over_range = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    sample_data = 8'($urandom(32'ha1ce));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    #1 check(16'(buffer_flags), 16'h0002);
    // registers: reset value, writable mask, unmapped place
    rd_chk(scbc_pkg::BUF_CTRL_OFFSET, 16'h0000);
    reg_wr(scbc_pkg::BUF_CTRL_OFFSET, 16'hffff);
    rd_chk(scbc_pkg::BUF_CTRL_OFFSET, scbc_pkg::BUF_CTRL_MASK);
    reg_wr(8'h3c, 16'hffff);
    rd_chk(8'h3c, 16'h0000);
    reg_wr(scbc_pkg::BUF_CTRL_OFFSET, 16'h0000);
    $display("test registers done");
    // single port: random length burst with an over-range sample
    n = 8 + int'($urandom % 5);
    write_burst(n, n - 1);
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(n, 1'b0, 1'b0, 1'b1));
    drain(n);
    chk_seq();
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(0, 1'b0, 1'b1, 1'b0));
    check(later_sample_port, rd_q[n - 1]);
    check(earlier_sample_port_oe, 1'b0);
    $display("test single port done");
    // wrap mode: 20 writes into 16 places keep the newest
    write_burst(20, 99);
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(16, 1'b1, 1'b0, 1'b0));
    drain(16);
    chk_seq();
    d_wrap = rd_q[15] - v_drop;
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(0, 1'b0, 1'b1, 1'b0));
    $display("test wrap done");
    // stop mode: the first 16 stay, so the newest is four older
    reg_wr(scbc_pkg::BUF_CTRL_OFFSET, 16'h2000);
    write_burst(20, 99);
    check(capture_accept, 1'b0);
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(16, 1'b1, 1'b0, 1'b0));
    drain(16);
    chk_seq();
    d_stop = rd_q[15] - v_drop;
    check(step(d_stop, 4), d_wrap);
    $display("test stop on full done");
    // dual port: earlier byte on the second port, both strobes
    reg_wr(scbc_pkg::BUF_CTRL_OFFSET, 16'h1000);
    #1 check(earlier_sample_port_oe, 1'b1);
    // an odd count leaves a lone last byte: earlier gets it, later holds
    write_burst(7, 99);
    drain(4);
    for (int i = 0; i < 4; i++)
    begin
      check(er_q[i], step(er_q[0], 2 * i));
      check(rd_q[i], step(er_q[i], (i < 3) ? 1 : -1));
    end
    $display("test dual port done");
    // buffer reset from full with over-range pending
    write_burst(20, 19);
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(16, 1'b1, 1'b0, 1'b1));
    @(posedge clock);
    brst_cmd <= 1'b1;
    repeat (6) @(posedge clock);
    brst_cmd <= 1'b0;
    repeat (10) @(posedge clock);
    rd_chk(scbc_pkg::STATUS_OFFSET, stat(0, 1'b0, 1'b1, 1'b0));
    rd_chk(scbc_pkg::BUF_CTRL_OFFSET, 16'h1000);
    $display("test buffer reset done");
    stop_test();
  end
endmodule
